/* File: hw/pcc_top.v */
// pll clock configuration, mode and supervisory logic with apb slave
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
`include "pcc_map.vh"

// Operation
// - auto mode: tracking bit read-only, shows loop's present tracking state
// - manual mode: tracking bit writable, forces loop tracking or acquisition
// - manual tracking value kept in shadow during auto, restored on manual
// - tracking is 1, acquisition 0; reset clears to acquisition
// - 12-bit multiplier: bits 11:8 high register, 7:0 low register
// - multiplier zero behaves as one
// - loop enable set blocks writes to multiplier, range, divider registers
// - 8-bit range field gives linear multiplier L, with power range
// - range zero disables loop, clears select, refuses setting select
// - reset loads range register for factor sixty-four
// - reference divider field sets R; zero behaves as one
// - divider upper four bits unimplemented, ignore writes, read zero
// - auto mode: lock change sets flag always; request only when enabled
// - manual mode: requests blocked, flag reads zero
// - halved vco clock selectable even while unlocked
// - wait mode leaves all state and outputs unchanged
// - stop forces crystal clock, base clock and interrupt outputs low
// - stop with vco selected clears select; crystal drives afterwards
// - break with clear enable 0 protects flag; with 1 reads clear it
// - a read of loop control register clears flag unless break protects it or a lock change sets it in that cycle; reset clears too
// - select 1 routes vco/2, select 0 routes crystal/2 to base clock
// - auto: lock read-only, set when locked; manual: reads zero
module pcc_top #(
  parameter MUL_W = 12,
  parameter VRS_W = 8,
  parameter RDS_W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire crystal_clock,
  input wire vco_clock,
  input wire loop_locked,
  input wire loop_tracking,
  input wire wait_mode,
  input wire stop_mode,
  input wire break_active,
  input wire break_flag_clear_enable,
  output reg crystal_clock_out,
  output reg base_clock_out,
  output reg loop_interrupt_out,
  output reg loop_enable_out,
  output reg auto_bandwidth_out,
  output reg tracking_force_out,
  output reg [MUL_W-1:0] feedback_factor_out,
  output reg [VRS_W-1:0] vco_linear_range_out,
  output reg [1:0] vco_power_range_out,
  output reg [1:0] prescaler_out,
  output reg [RDS_W-1:0] ref_division_out
);

  // control state
  reg irq_enable_r;
  reg irq_flag_r;
  reg loop_enable_r;
  reg bcs_r;
  reg [1:0] prescale_r;
  reg [1:0] vpr_r;
  reg auto_r;
  reg trk_shadow_r;
  reg [MUL_W-1:0] mul_r;
  reg [VRS_W-1:0] vrs_r;
  reg [RDS_W-1:0] rds_r;

  // synchronisers and edge history
  reg lock_s1_r;
  reg lock_s2_r;
  reg lock_q_r;
  reg trk_s1_r;
  reg trk_s2_r;
  reg xclk_q_r;
  reg vclk_q_r;
  reg stop_q_r;

  wire acc_done;
  wire wr_done;
  wire rd_done;
  wire [7:0] wbyte;
  wire sel_ctl;
  wire sel_bwc;
  wire sel_msh;
  wire sel_msl;
  wire sel_vrs;
  wire sel_rds;
  wire mapped;
  wire prog_open;
  wire vrs_zero;
  wire lock_edge;
  wire flag_clear;
  wire flag_set;
  wire lock_view;
  wire trk_view;
  wire stop_entry;
  reg [7:0] rd_byte;

  assign acc_done = psel & penable & pready;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign sel_ctl = (paddr == `PCC_OFS_CTL);
  assign sel_bwc = (paddr == `PCC_OFS_BWC);
  assign sel_msh = (paddr == `PCC_OFS_MSH);
  assign sel_msl = (paddr == `PCC_OFS_MSL);
  assign sel_vrs = (paddr == `PCC_OFS_VRS);
  assign sel_rds = (paddr == `PCC_OFS_RDS);
  assign mapped = sel_ctl | sel_bwc | sel_msh | sel_msl | sel_vrs | sel_rds;
  // programming registers freeze while the loop runs
  assign prog_open = ~loop_enable_r;
  assign vrs_zero = (vrs_r == `PCC_VRS_ZERO);
  assign lock_edge = lock_s2_r ^ lock_q_r;
  assign lock_view = auto_r & lock_s2_r;
  assign trk_view = auto_r ? trk_s2_r : trk_shadow_r;
  // break protection: reads clear only when break clearing is allowed
  assign flag_clear = rd_done & sel_ctl &
    (~break_active | break_flag_clear_enable);
  assign flag_set = auto_r & lock_edge;
  assign stop_entry = stop_mode & ~stop_q_r;

  always @* begin
    rd_byte = 8'h00;
    case (1'b1)
      sel_ctl: begin
        rd_byte[`PCC_CTL_IE] = irq_enable_r & auto_r;
        rd_byte[`PCC_CTL_FLAG] = irq_flag_r & auto_r;
        rd_byte[`PCC_CTL_ON] = loop_enable_r;
        rd_byte[`PCC_CTL_BCS] = bcs_r;
        rd_byte[`PCC_CTL_PRE_HI:`PCC_CTL_PRE_LO] = prescale_r;
        rd_byte[`PCC_CTL_VPR_HI:`PCC_CTL_VPR_LO] = vpr_r;
      end
      sel_bwc: begin
        rd_byte[`PCC_BWC_AUTO] = auto_r;
        rd_byte[`PCC_BWC_LOCK] = lock_view;
        rd_byte[`PCC_BWC_TRK] = trk_view;
      end
      sel_msh: rd_byte = {4'h0, mul_r[11:8]};
      sel_msl: rd_byte = mul_r[7:0];
      sel_vrs: rd_byte = vrs_r;
      sel_rds: rd_byte = {4'h0, rds_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // apb: one wait state, answer in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= (pwrite | ~mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // lock and tracking synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      lock_q_r <= 1'b0;
      trk_s1_r <= 1'b0;
      trk_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= loop_locked;
      lock_s2_r <= lock_s1_r;
      lock_q_r <= lock_s2_r;
      trk_s1_r <= loop_tracking;
      trk_s2_r <= trk_s1_r;
    end
  end

  // loop control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= 1'b0;
      irq_flag_r <= 1'b0;
      loop_enable_r <= `PCC_RST_ON;
      bcs_r <= 1'b0;
      prescale_r <= 2'b00;
      vpr_r <= 2'b00;
      stop_q_r <= 1'b0;
    end else begin
      stop_q_r <= stop_mode;
      // a lock change in the clearing cycle must not be lost
      if (flag_set)
        irq_flag_r <= 1'b1;
      else if (flag_clear)
        irq_flag_r <= 1'b0;
      if (wr_done & sel_ctl) begin
        if (auto_r)
          irq_enable_r <= wbyte[`PCC_CTL_IE];
        // enable cannot drop while the vco drives the base clock
        loop_enable_r <= wbyte[`PCC_CTL_ON] | bcs_r;
        if (prog_open) begin
          prescale_r <= wbyte[`PCC_CTL_PRE_HI:`PCC_CTL_PRE_LO];
          vpr_r <= wbyte[`PCC_CTL_VPR_HI:`PCC_CTL_VPR_LO];
        end
        // select honoured without lock; needs loop on and range set
        bcs_r <= wbyte[`PCC_CTL_BCS] & loop_enable_r & ~vrs_zero &
          ~stop_mode;
      end else if (vrs_zero | ~loop_enable_r) begin
        bcs_r <= 1'b0;
      end
      if (stop_entry & bcs_r)
        bcs_r <= 1'b0;
    end
  end

  // bandwidth control register and tracking shadow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_r <= 1'b0;
      trk_shadow_r <= 1'b0;
    end else if (wr_done & sel_bwc) begin
      auto_r <= wbyte[`PCC_BWC_AUTO];
      // shadow only takes writes made in manual mode
      if (~auto_r)
        trk_shadow_r <= wbyte[`PCC_BWC_TRK];
    end
  end

  // programming registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul_r <= `PCC_RST_MUL;
      vrs_r <= `PCC_RST_VRS;
      rds_r <= `PCC_RST_RDS;
    end else if (wr_done & prog_open) begin
      if (sel_msh)
        mul_r[11:8] <= wbyte[3:0];
      if (sel_msl)
        mul_r[7:0] <= wbyte;
      if (sel_vrs)
        vrs_r <= wbyte;
      if (sel_rds)
        rds_r <= wbyte[3:0];
    end
  end

  // settings presented to the analog loop; stop disables the generator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_enable_out <= 1'b0;
      auto_bandwidth_out <= 1'b0;
      tracking_force_out <= 1'b0;
      feedback_factor_out <= `PCC_MUL_ONE;
      vco_linear_range_out <= `PCC_VRS_ZERO;
      vco_power_range_out <= 2'b00;
      prescaler_out <= 2'b00;
      ref_division_out <= `PCC_RDS_ONE;
    end else begin
      loop_enable_out <= loop_enable_r & ~vrs_zero & ~stop_mode;
      auto_bandwidth_out <= auto_r;
      tracking_force_out <= trk_shadow_r;
      feedback_factor_out <= (mul_r == `PCC_MUL_ZERO) ?
        `PCC_MUL_ONE : mul_r;
      vco_linear_range_out <= vrs_r;
      vco_power_range_out <= vpr_r;
      prescaler_out <= prescale_r;
      ref_division_out <= (rds_r == `PCC_RDS_ZERO) ?
        `PCC_RDS_ONE : rds_r;
    end
  end

  // clock outputs; wait_mode deliberately has no effect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xclk_q_r <= 1'b0;
      vclk_q_r <= 1'b0;
      crystal_clock_out <= 1'b0;
      base_clock_out <= 1'b0;
      loop_interrupt_out <= 1'b0;
    end else begin
      xclk_q_r <= crystal_clock;
      vclk_q_r <= vco_clock;
      if (stop_mode) begin
        crystal_clock_out <= 1'b0;
        base_clock_out <= 1'b0;
        loop_interrupt_out <= 1'b0;
      end else begin
        crystal_clock_out <= crystal_clock;
        // halve the selected source on its rising edges
        if (bcs_r ? (vco_clock & ~vclk_q_r) : (crystal_clock & ~xclk_q_r))
          base_clock_out <= ~base_clock_out;
        loop_interrupt_out <= auto_r & irq_enable_r & irq_flag_r;
      end
    end
  end

  // wait_mode is observed only so that it is not an unread port
  wire unused_ok;
  assign unused_ok = wait_mode & pwdata[31];

endmodule // pcc_top
`default_nettype wire

/* File: common/pcc_map.vh */
// register map, field positions and reset values of the pll config block
`ifndef PCC_MAP_VH
`define PCC_MAP_VH
`define PCC_OFS_CTL 8'h00
`define PCC_OFS_BWC 8'h04
`define PCC_OFS_MSH 8'h08
`define PCC_OFS_MSL 8'h0C
`define PCC_OFS_VRS 8'h10
`define PCC_OFS_RDS 8'h14
`define PCC_CTL_IE 7
`define PCC_CTL_FLAG 6
`define PCC_CTL_ON 5
`define PCC_CTL_BCS 4
`define PCC_CTL_PRE_HI 3
`define PCC_CTL_PRE_LO 2
`define PCC_CTL_VPR_HI 1
`define PCC_CTL_VPR_LO 0
`define PCC_BWC_AUTO 7
`define PCC_BWC_LOCK 6
`define PCC_BWC_TRK 5
`define PCC_RST_MUL 12'h040
`define PCC_RST_VRS 8'h40
`define PCC_RST_RDS 4'h1
`define PCC_RST_ON 1'b1
`define PCC_MUL_ONE 12'h001
`define PCC_RDS_ONE 4'h1
`define PCC_VRS_ZERO 8'h00
`define PCC_MUL_ZERO 12'h000
`define PCC_RDS_ZERO 4'h0
`endif

/* File: tb/pcc_top_asserts.sv */
// port assertions for the pll configuration block
`default_nettype none
module pcc_top_asserts #(
  parameter MUL_W = 12,
  parameter VRS_W = 8,
  parameter RDS_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic stop_mode,
  input wire logic crystal_clock_out,
  input wire logic base_clock_out,
  input wire logic loop_interrupt_out,
  input wire logic loop_enable_out,
  input wire logic auto_bandwidth_out,
  input wire logic [MUL_W-1:0] feedback_factor_out,
  input wire logic [VRS_W-1:0] vco_linear_range_out,
  input wire logic [RDS_W-1:0] ref_division_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wait_one_a: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready held");
  stop_quiet_a: assert property (stop_mode |=>
    !crystal_clock_out && !base_clock_out && !loop_interrupt_out)
    else $error("outputs live in stop");
  manual_irq_a: assert property (
    !auto_bandwidth_out && !$past(auto_bandwidth_out) |->
    !loop_interrupt_out) else $error("irq in manual");
  mul_nonzero_a: assert property (
    feedback_factor_out != '0) else $error("factor zero");
  div_nonzero_a: assert property (
    ref_division_out != '0) else $error("divider zero");
  range_zero_a: assert property ($past(presetn) &&
    vco_linear_range_out == '0 |=> !loop_enable_out)
    else $error("loop on at range zero");
  locked_cfg_a: assert property ($past(presetn, 2) &&
    loop_enable_out && $past(loop_enable_out) |->
    $stable(feedback_factor_out) && $stable(vco_linear_range_out))
    else $error("config moved while on");
  cover property (loop_interrupt_out);
  cover property ($rose(stop_mode));
  cover property (vco_linear_range_out == '0);
endmodule // pcc_top_asserts
bind pcc_top pcc_top_asserts #(.MUL_W(MUL_W), .VRS_W(VRS_W),
  .RDS_W(RDS_W)) u_pcc_top_asserts (.pclk, .presetn, .psel, .penable,
  .pready, .stop_mode, .crystal_clock_out, .base_clock_out,
  .loop_interrupt_out, .loop_enable_out, .auto_bandwidth_out,
  .feedback_factor_out, .vco_linear_range_out, .ref_division_out);
`default_nettype wire

/* File: tb/pcc_top_test.sv */
// self-checking bench for the pll configuration block
`default_nettype none
`include "pcc_map.vh"
module pcc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic xc = '0, vc = '0, lk = '0, tk = '0, wt = '0, stp = '0;
  logic brk = '0, bce = '0, serr;
  logic [31:0] rdat;
  wire [31:0] prdata;
  wire pready, pslverr, xo, bo, io, lo, ao, fo;
  wire [11:0] ffo;
  wire [7:0] vro;
  wire [3:0] rdo;
  int err_count = 0, checked = 0, cyc = 0;
  pcc_top u_pcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock(xc), .vco_clock(vc), .loop_locked(lk),
    .loop_tracking(tk), .wait_mode(wt), .stop_mode(stp),
    .break_active(brk), .break_flag_clear_enable(bce),
    .crystal_clock_out(xo), .base_clock_out(bo), .loop_interrupt_out(io),
    .loop_enable_out(lo), .auto_bandwidth_out(ao),
    .tracking_force_out(fo), .feedback_factor_out(ffo),
    .vco_linear_range_out(vro), .vco_power_range_out(),
    .prescaler_out(), .ref_division_out(rdo));
  always #2.5 pclk = ~pclk;
  // slow stand-ins, kept well under half the bus clock
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 0) xc <= ~xc;
    if (cyc % 2 == 0) vc <= ~vc;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // second edge lets registered outputs settle before checks
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdat, {24'h00_0000, e});
  endtask
  task automatic tend(input string s);
    $display("test %s over", s);
  endtask
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`PCC_OFS_CTL, 8'h20);
    rd(`PCC_OFS_BWC, 8'h00);
    rd(`PCC_OFS_MSH, 8'h00);
    rd(`PCC_OFS_MSL, 8'h40);
    rd(`PCC_OFS_VRS, 8'h40);
    rd(`PCC_OFS_RDS, 8'h01);
    chk(ffo, 12'h040);
    tend("reset");
    wr(`PCC_OFS_MSL, 8'h00);
    wr(`PCC_OFS_VRS, 8'h00);
    wr(`PCC_OFS_RDS, 8'h05);
    rd(`PCC_OFS_MSL, 8'h40);
    rd(`PCC_OFS_VRS, 8'h40);
    rd(`PCC_OFS_RDS, 8'h01);
    wt <= 1'b1;
    wr(`PCC_OFS_CTL, 8'h30);
    rd(`PCC_OFS_CTL, 8'h30);
    chk(lo, 1'b1);
    wt <= 1'b0;
    wr(`PCC_OFS_CTL, 8'h00);
    rd(`PCC_OFS_CTL, 8'h20);
    wr(`PCC_OFS_CTL, 8'h00);
    wr(`PCC_OFS_MSH, 8'hFF);
    rd(`PCC_OFS_MSH, 8'h0F);
    chk(ffo, 12'hF40);
    wr(`PCC_OFS_MSH, 8'h00);
    wr(`PCC_OFS_MSL, 8'h00);
    chk(ffo, 12'h001);
    wr(`PCC_OFS_RDS, 8'hF0);
    rd(`PCC_OFS_RDS, 8'h00);
    chk(rdo, 4'h1);
    wr(`PCC_OFS_RDS, 8'h07);
    chk(rdo, 4'h7);
    wr(`PCC_OFS_VRS, 8'h00);
    wr(`PCC_OFS_CTL, 8'h30);
    rd(`PCC_OFS_CTL, 8'h20);
    chk({vro, lo}, 9'h000);
    wr(`PCC_OFS_CTL, 8'h00);
    wr(`PCC_OFS_VRS, 8'h40);
    chk(vro, 8'h40);
    tend("fields");
    wr(`PCC_OFS_BWC, 8'h20);
    rd(`PCC_OFS_BWC, 8'h20);
    chk(fo, 1'b1);
    wr(`PCC_OFS_BWC, 8'hA0);
    wr(`PCC_OFS_BWC, 8'h80);
    rd(`PCC_OFS_BWC, 8'h80);
    tk <= 1'b1;
    settle();
    rd(`PCC_OFS_BWC, 8'hA0);
    tk <= 1'b0;
    wr(`PCC_OFS_BWC, 8'h00);
    rd(`PCC_OFS_BWC, 8'h20);
    tend("bandwidth");
    wr(`PCC_OFS_BWC, 8'h80);
    wr(`PCC_OFS_CTL, 8'hA0);
    lk <= 1'b1;
    settle();
    chk(io, 1'b1);
    rd(`PCC_OFS_BWC, 8'hC0);
    rd(`PCC_OFS_CTL, 8'hE0);
    rd(`PCC_OFS_CTL, 8'hA0);
    chk(io, 1'b0);
    wr(`PCC_OFS_CTL, 8'h20);
    lk <= 1'b0;
    settle();
    chk(io, 1'b0);
    brk <= 1'b1;
    rd(`PCC_OFS_CTL, 8'h60);
    rd(`PCC_OFS_CTL, 8'h60);
    bce <= 1'b1;
    rd(`PCC_OFS_CTL, 8'h60);
    brk <= 1'b0;
    bce <= 1'b0;
    rd(`PCC_OFS_CTL, 8'h20);
    wr(`PCC_OFS_BWC, 8'h00);
    lk <= 1'b1;
    settle();
    chk(io, 1'b0);
    rd(`PCC_OFS_CTL, 8'h20);
    apb(1'b0, `PCC_OFS_BWC, 8'h00);
    chk(rdat[6], 1'b0);
    tend("interrupt");
    wr(`PCC_OFS_CTL, 8'h30);
    stp <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({xo, bo, io}, 3'h0);
    stp <= 1'b0;
    apb(1'b0, `PCC_OFS_CTL, 8'h00);
    chk(rdat[4], 1'b0);
    tend("stop");
    wr(8'h18, 8'h55);
    apb(1'b0, 8'h18, 8'h00);
    chk({serr, rdat}, 33'h1_0000_0000);
    tend("bus");
    give_verdict();
  end
endmodule // pcc_top_test
`default_nettype wire
